// [design/cpd_cfg.svh]
// register map, result codes, area sizes and timing of the poll data area block
`ifndef CPD_CFG_SVH
`define CPD_CFG_SVH

`define CPD_A_CTRL        12'h000
`define CPD_A_RD_BASE     12'h004
`define CPD_A_WR_BASE     12'h008
`define CPD_A_STATUS      12'h00c
`define CPD_A_INT_STAT    12'h010
`define CPD_A_INT_MASK    12'h014
`define CPD_MEM_SEL       2'h1

`define CPD_CTRL_START    0
`define CPD_CTRL_WRITE    1
`define CPD_CTRL_PM       2
`define CPD_CTRL_GRP_LSB  4
`define CPD_CTRL_CNT_LSB  8
`define CPD_CTRL_RST      32'h0000_0010

`define CPD_INT_DONE      0
`define CPD_INT_ERR       1

`define CPD_RESP_OK       2'h0
`define CPD_RESP_SLVERR   2'h2

`define CPD_EC_MARK       8'hff
`define CPD_EC_ADDR_OVF   16'hff04
`define CPD_EC_NO_EXEC    16'hff0d
`define CPD_EC_PARITY     16'hff10
`define CPD_EC_FRAMING    16'hff11
`define CPD_EC_OVERRUN    16'hff12
`define CPD_EC_BLOCK_CHK  16'hff13
`define CPD_EC_FORMAT     16'hff14
`define CPD_EC_NUMERIC    16'hff15
`define CPD_EC_SUBADDR    16'hff16
`define CPD_EC_FRAME_LEN  16'hff18
`define CPD_EC_NV_WRITE   16'hff21
`define CPD_EC_RSP_BCC    16'hff97
`define CPD_TIMEOUT_CODE  16'he999
`define CPD_OPCMD_NO_SV   16'h0600

`define CPD_TC_LEN        5'd11
`define CPD_PM_LEN        5'd18
`define CPD_WR_LEN        5'd26
`define CPD_VAR_MAX       4'd12
`define CPD_PM_CLR_LO     5'd4
`define CPD_PM_CLR_HI     5'd9

`define CPD_CLK_KHZ       50000
`define CPD_TMO_MS        100

`endif

// [design/cpd_pkg.sv]
// types shared by the poll data area block
package cpd_pkg;

    typedef enum logic [3:0]
    {
        cause_parity, cause_framing, cause_overrun, cause_block_check, cause_rsp_block_check,
        cause_addr_ovf, cause_no_exec, cause_format, cause_numeric, cause_subaddr,
        cause_frame_len, cause_nv_write
    } cpd_cause_t;

    typedef enum logic [1:0]
    {
        lk_read, lk_write, lk_cmd
    } cpd_lkop_t;

    typedef enum logic [3:0]
    {
        st_idle, st_rscan, st_rreq, st_rwait, st_wop, st_wopd, st_wlo, st_whi,
        st_wreq, st_wwait, st_creq, st_cwait, st_mon
    } cpd_state_t;

endpackage : cpd_pkg

// [design/cpd_mem.sv]
// single port data memory word store with registered read data
`timescale 1ns/1ps
module cpd_mem
#(
    parameter int unsigned AW = 8,
    parameter int unsigned DW = 16
)
(
    input  wire logic          aclk,
    input  wire logic          we,
    input  wire logic          re,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output      logic [DW-1:0] rdata
);
    logic [DW-1:0] store [0:(1<<AW)-1];

    always_ff @(posedge aclk)
    begin
        if (we)
            store[addr] <= wdata;
        if (re)
            rdata <= store[addr];
    end
endmodule : cpd_mem

// [design/cpd_top.sv]
// poll data area engine: result words, read and write areas, AXI4-Lite access
// Functional notes
// R1 - end code 00: instrument response code goes to the monitor word
// R2 - other end codes: error code with ff in the upper byte
// R3 - parity ff10, framing ff11, overrun ff12, check ff13, response check ff97
// R4 - address ff04, no exec ff0d, format ff14, numeric ff15, subaddr ff16, length ff18, nv ff21
// R5 - no answer from the instrument writes e999
// R6 - host puts command code in bits 15:8, related data in bits 7:0
// R7 - operation command 0600 suppresses all setpoint_value writes
// R8 - host issues ram and backup mode selects in one scan only
// R9 - write variable n: low word at 2n, high word at 2n+1, n 1..12
// R10 - comm error aborts the write; later variables and command not sent
// R11 - temperature controller read area is 11 words from the base
// R12 - groups 1,2 words 1-3; 3 adds 4-5; 4 adds 6-8; 5 adds 9-10
// R13 - words not read because of an error are set to 0000
// R14 - word 2 holds temperature status, word 10 heater current status
// R15 - panel meter read area is 18 words from the base
// R16 - meter words 1-3 all; 4-9 groups 2,3,5; 10-17 groups 4,5
// R17 - meter group 4 clears words 4 to 9
// R18 - same monitor code structure for both instrument kinds
// R19 - monitor word written after each transaction, before going idle
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "cpd_cfg.svh"
module cpd_top
#(
    parameter int unsigned MEM_AW  = 8,
    parameter int unsigned TMO_CYC = `CPD_TMO_MS * `CPD_CLK_KHZ
)
(
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [11:0]         s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output      logic                s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output      logic                s_axi_wready,
    output      logic [1:0]          s_axi_bresp,
    output      logic                s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [11:0]         s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output      logic                s_axi_arready,
    output      logic [31:0]         s_axi_rdata,
    output      logic [1:0]          s_axi_rresp,
    output      logic                s_axi_rvalid,
    input  wire logic                s_axi_rready,
    output      logic                irq,
    output      logic                lk_req,
    output      cpd_pkg::cpd_lkop_t  lk_op,
    output      logic [4:0]          lk_index,
    output      logic [31:0]         lk_wdata,
    output      logic [15:0]         lk_cmd,
    input  wire logic                lk_rsp_valid,
    input  wire logic                lk_rsp_err,
    input  wire cpd_pkg::cpd_cause_t lk_cause,
    input  wire logic [15:0]         lk_resp_code,
    input  wire logic [15:0]         lk_rdata
);
    import cpd_pkg::*;

    cpd_state_t        st_q;
    logic              aw_held_q, w_held_q, ar_held_q, rd_pend_q;
    logic [11:0]       aw_addr_q, ar_addr_q;
    logic [31:0]       w_data_q, ctrl_q;
    logic [3:0]        w_strb_q;
    logic [MEM_AW-1:0] rd_base_q, wr_base_q;
    logic [1:0]        int_stat_q, int_mask_q;
    logic              cfg_err_q, wr_mode_q, pm_q, abort_q;
    logic [2:0]        grp_q;
    logic [3:0]        cnt_q, var_q;
    logic [4:0]        off_q;
    logic [15:0]       mon_q, mon_last_q, opcmd_q, lo_q, m_rdata;
    logic [31:0]       tmo_q;

    function automatic logic in_grp(input logic pm, input logic [2:0] g, input logic [4:0] o);
        logic r;
        r = 1'b0;
        if (o <= 5'd3)
            r = 1'b1;
        else if (pm)
            r = (o <= 5'd9) ? (g == 3'd2 || g == 3'd3 || g == 3'd5) : (g == 3'd4 || g == 3'd5); // R16
        else if (o <= 5'd5)
            r = (g >= 3'd3); // R12
        else if (o <= 5'd8)
            r = (g >= 3'd4); // R12
        else
            r = (g == 3'd5); // R12 R14
        return r;
    endfunction : in_grp

    function automatic logic [15:0] err_code(input cpd_cause_t c);
        logic [15:0] r;
        case (c) // R2 R3 R4
            cause_parity:          r = `CPD_EC_PARITY;
            cause_framing:         r = `CPD_EC_FRAMING;
            cause_overrun:         r = `CPD_EC_OVERRUN;
            cause_block_check:     r = `CPD_EC_BLOCK_CHK;
            cause_rsp_block_check: r = `CPD_EC_RSP_BCC;
            cause_addr_ovf:        r = `CPD_EC_ADDR_OVF;
            cause_format:          r = `CPD_EC_FORMAT;
            cause_numeric:         r = `CPD_EC_NUMERIC;
            cause_subaddr:         r = `CPD_EC_SUBADDR;
            cause_frame_len:       r = `CPD_EC_FRAME_LEN;
            cause_nv_write:        r = `CPD_EC_NV_WRITE;
            default:               r = `CPD_EC_NO_EXEC;
        endcase
        return r;
    endfunction : err_code

    // bus side decode
    wire [31:0] wmask      = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    wire [31:0] w_merge_c  = (ctrl_q & ~wmask) | (w_data_q & wmask);
    wire        eng_idle   = (st_q == st_idle);
    wire        wr_is_mem  = (aw_addr_q[11:10] == `CPD_MEM_SEL);
    wire        rd_is_mem  = (ar_addr_q[11:10] == `CPD_MEM_SEL);
    wire        wr_go      = aw_held_q & w_held_q & ~s_axi_bvalid & (~wr_is_mem | eng_idle);
    wire        wr_ctrl    = wr_go & (aw_addr_q == `CPD_A_CTRL);
    wire        wr_rdb     = wr_go & (aw_addr_q == `CPD_A_RD_BASE);
    wire        wr_wrb     = wr_go & (aw_addr_q == `CPD_A_WR_BASE);
    wire        wr_istat   = wr_go & (aw_addr_q == `CPD_A_INT_STAT);
    wire        wr_imask   = wr_go & (aw_addr_q == `CPD_A_INT_MASK);
    wire        wr_hit     = wr_is_mem | wr_ctrl | wr_rdb | wr_wrb | wr_istat | wr_imask
                             | (aw_addr_q == `CPD_A_STATUS);
    wire        mem_wr_go  = wr_go & wr_is_mem & (w_strb_q[0] | w_strb_q[1]);
    wire        mem_rd_go  = ar_held_q & ~s_axi_rvalid & ~rd_pend_q & rd_is_mem & eng_idle & ~mem_wr_go;
    wire        reg_rd_go  = ar_held_q & ~s_axi_rvalid & ~rd_pend_q & ~rd_is_mem;

    // start request and area bounds
    wire        start_req  = wr_ctrl & w_strb_q[0] & w_data_q[`CPD_CTRL_START] & eng_idle;
    wire        n_write    = w_merge_c[`CPD_CTRL_WRITE];
    wire        n_pm       = w_merge_c[`CPD_CTRL_PM];
    wire [2:0]  n_grp      = w_merge_c[`CPD_CTRL_GRP_LSB +: 3];
    wire [3:0]  n_cnt      = w_merge_c[`CPD_CTRL_CNT_LSB +: 4];
    wire [4:0]  n_len      = n_write ? `CPD_WR_LEN : (n_pm ? `CPD_PM_LEN : `CPD_TC_LEN); // R11 R15
    wire [MEM_AW:0] n_end  = {1'b0, n_write ? wr_base_q : rd_base_q} + (MEM_AW+1)'(n_len);
    wire        n_ok       = (n_end <= (MEM_AW+1)'(1 << MEM_AW)) && (n_write || (n_grp >= 3'd1 && n_grp <= 3'd5));
    wire        start_go   = start_req & n_ok;
    wire        start_bad  = start_req & ~n_ok;

    // engine datapath
    wire [4:0]  area_len   = pm_q ? `CPD_PM_LEN : `CPD_TC_LEN;
    wire        at_end     = (off_q == area_len);
    wire        pm_clr     = pm_q && grp_q == 3'd4 && off_q >= `CPD_PM_CLR_LO && off_q <= `CPD_PM_CLR_HI;
    wire        word_in    = in_grp(pm_q, grp_q, off_q);
    wire        zero_word  = (st_q == st_rscan) & ~at_end & (pm_clr | (word_in & abort_q)); // R13 R17
    wire        fetch_word = (st_q == st_rscan) & ~at_end & ~zero_word & word_in;
    wire        waiting    = (st_q == st_rwait) | (st_q == st_wwait) | (st_q == st_cwait);
    wire        tmo_hit    = (tmo_q == TMO_CYC - 32'd1);
    wire        got_ok     = waiting & lk_rsp_valid & ~lk_rsp_err;
    wire        got_bad    = waiting & ~got_ok & ((lk_rsp_valid & lk_rsp_err) | tmo_hit);
    wire [15:0] bad_code   = lk_rsp_valid ? err_code(lk_cause) : `CPD_TIMEOUT_CODE; // R5
    wire        no_sv      = (opcmd_q == `CPD_OPCMD_NO_SV);
    wire [4:0]  off_sel    = (st_q == st_mon) ? 5'd0 : (st_q == st_wop) ? 5'd1 :
                             (st_q == st_wlo) ? {var_q, 1'b0} : (st_q == st_whi) ? {var_q, 1'b1} : off_q; // R9
    wire [MEM_AW-1:0] base_sel = wr_mode_q ? wr_base_q : rd_base_q;
    wire [MEM_AW-1:0] eng_addr = base_sel + MEM_AW'(off_sel);
    wire        eng_we     = zero_word | ((st_q == st_rwait) & (got_ok | got_bad)) | (st_q == st_mon);
    wire        eng_re     = (st_q == st_wop) | (st_q == st_wlo) | (st_q == st_whi);
    wire [15:0] eng_wdata  = (st_q == st_mon) ? mon_q : (got_ok ? lk_rdata : 16'h0000); // R13
    wire        m_we       = eng_idle ? mem_wr_go : eng_we;
    wire        m_re       = eng_idle ? mem_rd_go : eng_re;
    wire [MEM_AW-1:0] m_addr = ~eng_idle ? eng_addr :
                               (mem_wr_go ? aw_addr_q[MEM_AW+1:2] : ar_addr_q[MEM_AW+1:2]);
    wire [15:0] m_wdata    = eng_idle ? w_data_q[15:0] : eng_wdata;

    // register read view
    wire [31:0] reg_rdata  = (ar_addr_q == `CPD_A_CTRL)     ? ctrl_q :
                             (ar_addr_q == `CPD_A_RD_BASE)  ? 32'(rd_base_q) :
                             (ar_addr_q == `CPD_A_WR_BASE)  ? 32'(wr_base_q) :
                             (ar_addr_q == `CPD_A_STATUS)   ? {mon_last_q, 14'h0000, cfg_err_q, ~eng_idle} :
                             (ar_addr_q == `CPD_A_INT_STAT) ? 32'(int_stat_q) :
                             (ar_addr_q == `CPD_A_INT_MASK) ? 32'(int_mask_q) : 32'h0000_0000;
    wire        reg_hit    = (ar_addr_q[11:5] == 7'h00) && (ar_addr_q[4:2] <= 3'h5) && (ar_addr_q[1:0] == 2'h0);
    wire [1:0]  int_set    = {(st_q == st_mon) & abort_q | start_bad, st_q == st_mon};
    wire [1:0]  int_clr    = wr_istat & w_strb_q[0] ? w_data_q[1:0] : 2'h0;
    wire [1:0]  int_stat_d = (int_stat_q & ~int_clr) | int_set;

    cpd_mem #(.AW(MEM_AW), .DW(16)) u_mem
    (
        .aclk  (aclk),
        .we    (m_we),
        .re    (m_re),
        .addr  (m_addr),
        .wdata (m_wdata),
        .rdata (m_rdata)
    );

    // AXI4-Lite write channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            {aw_held_q, w_held_q, s_axi_bvalid} <= 3'h0;
            {s_axi_awready, s_axi_wready} <= 2'h3;
            s_axi_bresp <= `CPD_RESP_OK;
            aw_addr_q <= 12'h000;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
                {aw_held_q, s_axi_awready, aw_addr_q} <= {2'b10, s_axi_awaddr};
            if (s_axi_wvalid && s_axi_wready)
                {w_held_q, s_axi_wready, w_data_q, w_strb_q} <= {2'b10, s_axi_wdata, s_axi_wstrb};
            if (wr_go)
                {s_axi_bvalid, s_axi_bresp} <= {1'b1, wr_hit ? `CPD_RESP_OK : `CPD_RESP_SLVERR};
            if (s_axi_bvalid && s_axi_bready)
                {s_axi_bvalid, aw_held_q, w_held_q, s_axi_awready, s_axi_wready} <= 5'h03;
        end
    end

    // AXI4-Lite read channel; memory words take one extra cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            {ar_held_q, rd_pend_q, s_axi_rvalid} <= 3'h0;
            s_axi_arready <= 1'b1;
            ar_addr_q <= 12'h000;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CPD_RESP_OK;
        end
        else
        begin
            if (s_axi_arvalid && s_axi_arready)
                {ar_held_q, s_axi_arready, ar_addr_q} <= {2'b10, s_axi_araddr};
            rd_pend_q <= mem_rd_go;
            if (reg_rd_go)
                {s_axi_rvalid, s_axi_rdata, s_axi_rresp} <= {1'b1, reg_rdata, reg_hit ? `CPD_RESP_OK : `CPD_RESP_SLVERR};
            if (rd_pend_q)
                {s_axi_rvalid, s_axi_rdata, s_axi_rresp} <= {1'b1, 16'h0000, m_rdata, `CPD_RESP_OK};
            if (s_axi_rvalid && s_axi_rready)
                {s_axi_rvalid, ar_held_q, s_axi_arready} <= 3'h1;
        end
    end

    // software registers and interrupt
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_q <= `CPD_CTRL_RST;
            {rd_base_q, wr_base_q} <= '0;
            {int_stat_q, int_mask_q, cfg_err_q, irq} <= 6'h00;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= w_merge_c & ~(32'h1 << `CPD_CTRL_START);
            if (wr_rdb && w_strb_q[0])
                rd_base_q <= w_data_q[MEM_AW-1:0];
            if (wr_wrb && w_strb_q[0])
                wr_base_q <= w_data_q[MEM_AW-1:0];
            if (wr_imask && w_strb_q[0])
                int_mask_q <= w_data_q[1:0];
            if (start_req)
                cfg_err_q <= ~n_ok;
            int_stat_q <= int_stat_d;
            irq <= |(int_stat_d & int_mask_q);
        end
    end

    // engine sequence
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_q <= st_idle;
        else
        begin
            case (st_q)
                st_idle:  if (start_go) st_q <= n_write ? st_wop : st_rscan;
                st_rscan: if (at_end) st_q <= st_mon; else if (fetch_word) st_q <= st_rreq;
                st_rreq:  st_q <= st_rwait;
                st_rwait: if (got_ok || got_bad) st_q <= st_rscan;
                st_wop:   st_q <= st_wopd;
                st_wopd:  st_q <= st_wlo;
                st_wlo:   st_q <= (var_q > cnt_q || no_sv) ? st_creq : st_whi; // R7
                st_whi:   st_q <= st_wreq;
                st_wreq:  st_q <= st_wwait;
                st_wwait: if (got_ok) st_q <= st_wlo; else if (got_bad) st_q <= st_mon; // R10
                st_creq:  st_q <= st_cwait;
                st_cwait: if (got_ok || got_bad) st_q <= st_mon;
                st_mon:   st_q <= st_idle; // R19
                default:  st_q <= st_idle;
            endcase
        end
    end

    // engine working registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            {wr_mode_q, pm_q, abort_q, grp_q, cnt_q, var_q, off_q} <= '0;
            {mon_q, mon_last_q, opcmd_q, lo_q} <= '0;
            tmo_q <= 32'h0000_0000;
        end
        else
        begin
            if (start_go)
            begin
                {wr_mode_q, pm_q, grp_q, abort_q} <= {n_write, n_pm, n_grp, 1'b0};
                cnt_q <= (n_cnt > `CPD_VAR_MAX) ? `CPD_VAR_MAX : n_cnt;
                {off_q, var_q, mon_q} <= {5'd1, 4'd1, 16'h0000};
            end
            if ((st_q == st_rscan && !at_end && !fetch_word) || (st_q == st_rwait && (got_ok || got_bad)))
                off_q <= off_q + 5'd1;
            if (got_ok)
                mon_q <= lk_resp_code; // R1 R18
            if (got_bad)
                {mon_q, abort_q} <= {bad_code, 1'b1}; // R2 R5 R18
            if (st_q == st_wwait && got_ok)
                var_q <= var_q + 4'd1;
            if (st_q == st_wopd)
                opcmd_q <= m_rdata;
            if (st_q == st_whi)
                lo_q <= m_rdata;
            if (st_q == st_mon)
                mon_last_q <= mon_q;
            tmo_q <= (waiting && !got_ok && !got_bad) ? tmo_q + 32'd1 : 32'h0000_0000;
        end
    end

    // link requests
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            {lk_req, lk_index, lk_wdata, lk_cmd} <= '0;
            lk_op <= lk_read;
        end
        else
        begin
            lk_req <= (st_q == st_rreq) | (st_q == st_wreq) | (st_q == st_creq);
            // port lk_cmd hides the enum literal, so the literal is scoped
            if (st_q == st_rreq || st_q == st_wreq || st_q == st_creq)
                lk_op <= (st_q == st_rreq) ? lk_read : (st_q == st_wreq) ? lk_write : cpd_pkg::lk_cmd;
            if (st_q == st_rreq)
                lk_index <= off_q;
            if (st_q == st_wreq)
                {lk_index, lk_wdata} <= {1'b0, var_q, m_rdata, lo_q}; // R9
            if (st_q == st_creq)
                {lk_index, lk_cmd} <= {5'd0, opcmd_q};
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ok_code_a: assert property ( // R1
        got_ok |=> mon_q == $past(lk_resp_code)) else $error("response code not stored");
    err_mark_a: assert property ( // R2
        waiting && lk_rsp_valid && lk_rsp_err |=> mon_q[15:8] == `CPD_EC_MARK) else $error("error mark missing");
    parity_code_a: assert property ( // R3
        waiting && lk_rsp_valid && lk_rsp_err && lk_cause == cause_parity |=> mon_q == 16'hff10)
        else $error("parity code wrong");
    nv_code_a: assert property ( // R4
        waiting && lk_rsp_valid && lk_rsp_err && lk_cause == cause_nv_write |=> mon_q == 16'hff21)
        else $error("nonvolatile code wrong");
    timeout_code_a: assert property ( // R5
        waiting && tmo_hit && !lk_rsp_valid |=> mon_q == 16'he999 && abort_q) else $error("timeout code wrong");
    no_sv_a: assert property ( // R7
        lk_req && lk_op == lk_write |-> opcmd_q != 16'h0600) else $error("setpoint written under 0600");
    abort_write_a: assert property ( // R10
        st_q == st_wwait && lk_rsp_valid && lk_rsp_err |=> st_q == st_mon ##1 st_q == st_idle && !lk_req)
        else $error("write not aborted");
    tc_group_a: assert property ( // R12
        lk_req && lk_op == lk_read && !pm_q && grp_q < 3'h3 |-> lk_index <= 5'h3) else $error("word outside group");
    pm_clear_a: assert property ( // R17
        zero_word && pm_clr |-> m_we && m_wdata == 16'h0000 ##1 !(lk_req && lk_index inside {[4:9]}))
        else $error("meter group 4 words not cleared");
    mon_last_a: assert property ( // R19
        (st_q == st_rscan && at_end) || (st_q == st_cwait && (got_ok || got_bad))
        |=> st_q == st_mon && m_we && m_addr == base_sel) else $error("monitor word not written");

    read_done_c: cover property (st_q == st_rscan && at_end && !abort_q);
    write_abort_c: cover property (st_q == st_wwait && got_bad);
    timeout_c: cover property (waiting && tmo_hit && !lk_rsp_valid);
endmodule : cpd_top

// [bench/cpd_link_model.sv]
// instrument partner: answers each poll three cycles later, except while mute is set
`timescale 1ns/1ps
module cpd_link_model
(
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic                lk_req,
    input  wire cpd_pkg::cpd_lkop_t  lk_op,
    input  wire logic [4:0]          lk_index,
    input  wire logic                mute,
    input  wire logic [4:0]          fail_idx,
    input  wire cpd_pkg::cpd_cause_t fail_cause,
    output      logic                lk_rsp_valid,
    output      logic                lk_rsp_err,
    output      cpd_pkg::cpd_cause_t lk_cause,
    output      logic [15:0]         lk_resp_code,
    output      logic [15:0]         lk_rdata,
    output      logic [7:0]          wr_cnt,
    output      logic [7:0]          cmd_cnt
);
    import cpd_pkg::*;
    logic [1:0] dly_q;
    always_ff @(posedge aclk)
    begin
        dly_q <= {dly_q[0], lk_req & ~mute & aresetn};
        lk_rsp_valid <= dly_q[1];
        lk_rsp_err <= dly_q[1] && lk_index == fail_idx;
        lk_cause <= fail_cause;
        // outside an answer the lines change every cycle
        lk_resp_code <= !aresetn ? 16'h0001 : dly_q[1] ? 16'h0000 : ~lk_resp_code;
        lk_rdata <= !aresetn ? 16'h0 : dly_q[1] ? {11'h400, lk_index} : ~lk_rdata;
        wr_cnt <= !aresetn ? 8'h0 : wr_cnt + 8'(lk_req && lk_op == lk_write);
        cmd_cnt <= !aresetn ? 8'h0 : cmd_cnt + 8'(lk_req && lk_op == lk_cmd);
    end
endmodule : cpd_link_model

// [bench/tb_top.sv]
// self-checking testbench of the poll data area engine
`timescale 1ns/1ps
module tb_top;
    import cpd_pkg::*;
    logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, mute = 0;
    logic        awr, wrd, bv, arr, rv, irq, lk_req, lk_rsp_valid, lk_rsp_err;
    logic [11:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rd, q, lk_wdata;
    logic [1:0]  bresp, rresp;
    logic [4:0]  lk_index, fail_idx = 0;
    logic [15:0] lk_cmd, lk_resp_code, lk_rdata;
    logic [7:0]  wr_cnt, cmd_cnt;
    cpd_lkop_t   lk_op;
    cpd_cause_t  lk_cause, fail_cause = cause_parity;
    int          failures = 0, tests_run = 0;
    always #10 aclk = ~aclk;
    cpd_top #(.TMO_CYC(50)) i_cpd_top (.aclk, .aresetn, .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .irq, .lk_req, .lk_op, .lk_index, .lk_wdata, .lk_cmd, .lk_rsp_valid, .lk_rsp_err, .lk_cause,
        .lk_resp_code, .lk_rdata);
    cpd_link_model i_cpd_link_model (.aclk, .aresetn, .lk_req, .lk_op, .lk_index, .mute, .fail_idx,
        .fail_cause, .lk_rsp_valid, .lk_rsp_err, .lk_cause, .lk_resp_code, .lk_rdata, .wr_cnt, .cmd_cnt);
    task automatic results;
        $display("failures %0d tests_run %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e)
        begin
            $display("Error %s expected %h seen %h", n, e, s);
            failures++;
        end
    endtask : chk
    task automatic hang;
        failures++;
        results();
    endtask : hang
    task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        @(posedge aclk);
        {awa, wd, awv, wv, br} <= {a, d, 3'b111};
        for (n = 0; n < 300; n++)
        begin
            @(posedge aclk);
            if (awr) awv <= 0;
            if (wrd) wv <= 0;
            if (bv) break;
        end
        br <= 0;
        if (n == 300) hang();
        chk("bresp", {30'h0, e}, {30'h0, bresp});
    endtask : axw
    task automatic axr(input logic [11:0] a);
        int n;
        @(posedge aclk);
        {ara, arv, rr} <= {a, 2'b11};
        for (n = 0; n < 300 && rv !== 1'b1; n++)
        begin
            @(posedge aclk);
            if (arr) arv <= 0;
        end
        q = rd;
        rr <= 0;
        if (n == 300) hang();
    endtask : axr
    task automatic mw(input int i, input logic [15:0] d);
        axw(12'(32'h400 + i * 4), {16'h0, d}, 2'h0);
    endtask : mw
    task automatic mchk(input int i, input logic [15:0] e);
        axr(12'(32'h400 + i * 4));
        chk("mem", {16'h0, e}, q);
    endtask : mchk
    task automatic run(input logic [31:0] c);
        int n;
        axw(12'h000, c, 2'h0);
        for (n = 0; n < 100; n++)
        begin
            axr(12'h00c);
            if (q[0] === 1'b0) break;
        end
        if (n == 100) hang();
    endtask : run
    task automatic t_tc_read;
        mw(20, 16'h1234);
        run(32'h11);
        for (int i = 1; i < 4; i++) mchk(16 + i, {11'h400, 5'(i)});
        mchk(20, 16'h1234);
        mchk(16, 16'h0000);
    endtask : t_tc_read
    task automatic t_causes;
        logic [15:0] codes [12] = '{16'hff10, 16'hff11, 16'hff12, 16'hff13, 16'hff97, 16'hff04,
                                   16'hff0d, 16'hff14, 16'hff15, 16'hff16, 16'hff18, 16'hff21};
        fail_idx <= 3;
        for (int c = 0; c < 12; c++)
        begin
            fail_cause <= cpd_cause_t'(4'(c));
            run(32'h31);
            mchk(16, codes[c]);
        end
        mchk(18, 16'h8002);
        for (int i = 19; i < 22; i++) mchk(i, 16'h0000);
    endtask : t_causes
    task automatic t_tmo;
        fail_idx <= 0;
        mute <= 1;
        axw(12'h010, 32'h3, 2'h0);
        axw(12'h014, 32'h2, 2'h0);
        run(32'h11);
        mchk(16, 16'he999);
        chk("irq", 1, irq);
        axw(12'h010, 32'h3, 2'h0);
        mute <= 0;
        repeat (2) @(posedge aclk);
        chk("irq", 0, irq);
    endtask : t_tmo
    task automatic t_pm4;
        mw(25, 16'habcd);
        run(32'h45);
        mchk(20, 16'h0000);
        mchk(25, 16'h0000);
        mchk(33, 16'h8011);
        chk("irq", 0, irq);
    endtask : t_pm4
    logic [15:0] codes_w [4] = '{16'h1111, 16'h2222, 16'h3333, 16'h4444};
    task automatic t_wr;
        mw(49, 16'h0600);
        run(32'h103);
        chk("wr_cnt", 0, {24'h0, wr_cnt});
        chk("cmd_cnt", 1, {24'h0, cmd_cnt});
        chk("lk_cmd", 32'h0600, {16'h0, lk_cmd});
        foreach (codes_w[k]) mw(50 + k, codes_w[k]);
        mw(49, 16'h0100);
        fail_idx <= 2;
        run(32'h203);
        chk("wr_cnt", 2, {24'h0, wr_cnt});
        chk("cmd_cnt", 1, {24'h0, cmd_cnt});
        chk("lk_wdata", 32'h44443333, lk_wdata);
        mchk(48, 16'hff21);
    endtask : t_wr
    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        axr(12'h000);
        chk("ctrl", 32'h10, q);
        axw(12'h004, 32'h10, 2'h0);
        axw(12'h008, 32'h30, 2'h0);
        axw(12'h020, 32'h1, 2'h2);
        axr(12'h020);
        chk("rresp", 32'h2, {30'h0, rresp});
        t_tc_read();
        t_causes();
        t_tmo();
        t_pm4();
        t_wr();
        results();
    end
endmodule : tb_top
